//--- mdu_pkg.sv
// Package of addresses, bit positions, reset values and timing for the multiply/divide unit
package mdu_pkg;

  // Data widths
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;

  // I/O memory addresses of the unit
  localparam logic [15:0] ADDR_CLK_GATE = 16'hFF16;
  localparam logic [15:0] ADDR_SRC_LO = 16'hFF70;
  localparam logic [15:0] ADDR_SRC_HI = 16'hFF71;
  localparam logic [15:0] ADDR_DL_LO = 16'hFF72;
  localparam logic [15:0] ADDR_DL_HI = 16'hFF73;
  localparam logic [15:0] ADDR_DH_LO = 16'hFF74;
  localparam logic [15:0] ADDR_DH_HI = 16'hFF75;
  localparam logic [15:0] ADDR_CTRL = 16'hFF76;

  // Bit positions inside the nibbles
  localparam int GATE_BIT = 3;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ZERO_BIT = 1;
  localparam int CTRL_OVF_BIT = 2;
  localparam int CTRL_MSB_BIT = 3;

  // Values after reset
  localparam logic GATE_RST = 1'b0;
  localparam logic BUSY_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [3:0] RDATA_RST = 4'h0;

  // Calculation length in CPU clock cycles
  localparam int CALC_CYCLES = 10;
  localparam int CNT_W = 4;
  localparam logic [3:0] CALC_CNT_LOAD = 4'(CALC_CYCLES);
  localparam logic [3:0] CALC_CNT_LAST = 4'h1;
  localparam logic [3:0] CALC_CNT_IDLE = 4'h0;

  // Mode written with the start bit
  localparam logic MODE_MUL = 1'b0;
  localparam logic MODE_DIV = 1'b1;

endpackage

//--- mdu_if.sv
// Interface between the register front end and the arithmetic sequencer
`timescale 1ns/1ps
interface mdu_if;
  logic start;          // One-cycle start pulse
  logic div_mode;       // 1 divide, 0 multiply
  logic [15:0] dividend; // High and low destination bytes
  logic [7:0] divisor;  // Source operand
  logic clk_en;         // CPU clock enable pulse
  logic done;           // One-cycle completion pulse
  logic [7:0] res_lo;   // Product low byte or quotient
  logic [7:0] res_hi;   // Product high byte or remainder
  logic ovf;            // Quotient does not fit 8 bits

  modport core (output start, output div_mode, output dividend, output divisor,
    output clk_en, input done, input res_lo, input res_hi, input ovf);
  modport arith (input start, input div_mode, input dividend, input divisor,
    input clk_en, output done, output res_lo, output res_hi, output ovf);
endinterface

//--- mdu_clk_gate.sv
// Clock gate bit and CPU clock enable divider for the multiply/divide unit
`timescale 1ns/1ps
module mdu_clk_gate import mdu_pkg::*; #(
  parameter int CPU_CLK_DIV = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Gate bit write
  input wire logic gate_wr,
  input wire logic gate_bit,
  // Gate state and enable pulse
  output logic gate_q,
  output logic en_q
);

  logic [15:0] div_cnt_q; // Divider phase
  logic div_wrap;         // Last phase of the divider

  assign div_wrap = (div_cnt_q == 16'(CPU_CLK_DIV - 1));

  // Gate bit, reads back as written
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_q <= GATE_RST;
    end else if (gate_wr) begin
      gate_q <= gate_bit;
    end
  end

  // Divider only runs while the gate is on, saving toggles when idle
  always_ff @(posedge clk) begin
    if (reset || !gate_q) begin
      div_cnt_q <= 16'h0000;
    end else if (div_wrap) begin
      div_cnt_q <= 16'h0000;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  // One enable pulse per CPU clock, none while gated off
  always_ff @(posedge clk) begin
    if (reset) begin
      en_q <= 1'b0;
    end else begin
      en_q <= gate_q && div_wrap;
    end
  end

endmodule

//--- mdu_arith.sv
// Arithmetic sequencer: captures operands, counts CPU cycles, computes product or quotient
`timescale 1ns/1ps
module mdu_arith import mdu_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Front end side
  mdu_if.arith bus
);

  logic [3:0] cnt_q;       // Remaining CPU cycles, zero when idle
  logic mode_q;            // Captured mode
  logic [15:0] dvd_q;      // Captured multiplicand or dividend
  logic [7:0] dvs_q;       // Captured multiplier or divisor
  logic [15:0] prod;       // Unsigned product
  logic [15:0] quot;       // Unsigned quotient
  logic [7:0] rem;         // Unsigned remainder
  logic div_ovf;           // Quotient overflow

  // Operand capture at start; high byte ignored for multiply
  always_ff @(posedge clk) begin
    if (bus.start) begin
      mode_q <= bus.div_mode;
      dvd_q <= bus.div_mode ? bus.dividend : {8'h00, bus.dividend[7:0]};
      dvs_q <= bus.divisor;
    end
  end

  // Cycle counter; frozen while the clock is gated off
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= CALC_CNT_IDLE;
    end else if (bus.start) begin
      cnt_q <= CALC_CNT_LOAD;
    end else if (bus.clk_en && cnt_q != CALC_CNT_IDLE) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  // Unsigned arithmetic; a zero divisor is treated as overflow
  always_comb begin
    prod = {8'h00, dvd_q[7:0]} * {8'h00, dvs_q};
    div_ovf = (dvd_q[15:8] >= dvs_q);
    quot = (dvs_q == 8'h00) ? 16'hFFFF : dvd_q / {8'h00, dvs_q};
    rem = (dvs_q == 8'h00) ? 8'h00 : 8'(dvd_q % {8'h00, dvs_q});
  end

  assign bus.done = bus.clk_en && !bus.start && (cnt_q == CALC_CNT_LAST);
  assign bus.res_lo = mode_q ? quot[7:0] : prod[7:0];
  assign bus.res_hi = mode_q ? rem : prod[15:8];
  assign bus.ovf = mode_q && div_ovf;

  // Ten enabled CPU cycles from start to completion
  sequence s_step;
    bus.clk_en && !bus.start;
  endsequence
  sequence s_run;
    bus.start ##1 s_step[*8] ##1 s_step ##1 s_step;
  endsequence
  property p_done_after_ten;
    @(posedge clk) disable iff (reset) s_run |-> bus.done;
  endproperty
  a_done_after_ten: assert property (p_done_after_ten) else $error("no completion after ten cycles");

  // No completion in the first cycle after a start
  property p_no_early_done;
    @(posedge clk) disable iff (reset) bus.start |=> !bus.done;
  endproperty
  a_no_early_done: assert property (p_no_early_done) else $error("completion too early");

endmodule

//--- mdu_top.sv
// Multiply/divide unit: nibble register file, flags and sequencing
//
// Functional notes
// - Gate bit supplies CPU clock, reads back
// - Source operand split over two nibbles
// - Source operand held until rewritten
// - Low destination byte captured at start
// - Result loaded ten CPU cycles after start
// - Division overflow leaves destination unchanged
// - Multiply ignores high byte, gets product high
// - Divide uses high byte, gets remainder
// - Control bit write starts; value selects mode
// - Busy bit reads one while computing
// - Read-only zero indicator, reset clears
// - Overflow indicator; multiply always clears it
// - Sign indicator equals result MSB
// - Indicator bits ignore writes
// - All arithmetic is unsigned
// - Multiply sign follows high byte MSB
// - Multiply zero only for zero product
// - Divide flags follow low destination byte
`timescale 1ns/1ps
module mdu_top import mdu_pkg::*; #(
  parameter int CPU_CLK_DIV = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // CPU I/O memory bus
  input wire logic [15:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [3:0] wdata,
  // Read data
  output logic [3:0] rdata_q
);

  mdu_if arith_bus (); // Link to the sequencer

  logic [7:0] sr_q;   // Source operand
  logic [7:0] dl_q;   // Low destination byte
  logic [7:0] dh_q;   // High destination byte
  logic busy_q;       // Operation in progress
  logic mode_q;       // Mode of the running operation
  logic zf_q;         // Zero indicator
  logic vf_q;         // Overflow indicator
  logic nf_q;         // Sign indicator
  logic gate_q;       // Clock gate bit
  logic cpu_en;       // CPU clock enable pulse
  logic start;        // Control bit written
  logic ld_lo;        // Load low destination byte
  logic ld_hi;        // Load high destination byte
  logic [7:0] new_lo; // Low byte as it stands after completion
  logic [7:0] new_hi; // High byte as it stands after completion
  logic [3:0] rd_mux; // Read data before the register
  logic [7:0] chk_src_q; // Multiplier or divisor copy for the checks
  logic [15:0] chk_dvd_q; // Multiplicand or dividend copy for the checks

  // Gate bit and CPU clock enable
  mdu_clk_gate #(
    .CPU_CLK_DIV(CPU_CLK_DIV)
  ) u_gate (
    .clk(clk),
    .reset(reset),
    .gate_wr(wr && addr == ADDR_CLK_GATE),
    .gate_bit(wdata[GATE_BIT]),
    .gate_q(gate_q),
    .en_q(cpu_en)
  );

  // Arithmetic sequencer
  mdu_arith u_arith (
    .clk(clk),
    .reset(reset),
    .bus(arith_bus.arith)
  );

  // Any write to the control nibble starts an operation
  assign start = wr && (addr == ADDR_CTRL);

  // Operands go to the sequencer straight from the registers
  assign arith_bus.start = start;
  assign arith_bus.div_mode = wdata[CTRL_START_BIT];
  assign arith_bus.dividend = {dh_q, dl_q};
  assign arith_bus.divisor = sr_q;
  assign arith_bus.clk_en = cpu_en;

  // Completion loads; overflow suppresses both bytes
  assign ld_lo = arith_bus.done && !arith_bus.ovf;
  assign ld_hi = arith_bus.done && !arith_bus.ovf;
  assign new_lo = ld_lo ? arith_bus.res_lo : dl_q;
  assign new_hi = ld_hi ? arith_bus.res_hi : dh_q;

  // Source operand nibbles; no reset, content is undefined until written
  always_ff @(posedge clk) begin
    if (wr && addr == ADDR_SRC_LO) begin
      sr_q[3:0] <= wdata;
    end
    if (wr && addr == ADDR_SRC_HI) begin
      sr_q[7:4] <= wdata;
    end
  end

  // Low destination byte; completion wins over a stray write
  always_ff @(posedge clk) begin
    if (ld_lo) begin
      dl_q <= arith_bus.res_lo;
    end else begin
      if (wr && addr == ADDR_DL_LO) begin
        dl_q[3:0] <= wdata;
      end
      if (wr && addr == ADDR_DL_HI) begin
        dl_q[7:4] <= wdata;
      end
    end
  end

  // High destination byte; product high or remainder
  always_ff @(posedge clk) begin
    if (ld_hi) begin
      dh_q <= arith_bus.res_hi;
    end else begin
      if (wr && addr == ADDR_DH_LO) begin
        dh_q[3:0] <= wdata;
      end
      if (wr && addr == ADDR_DH_HI) begin
        dh_q[7:4] <= wdata;
      end
    end
  end

  // Busy bit; a new start in the completion cycle keeps it set
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q <= BUSY_RST;
      mode_q <= MODE_MUL;
    end else if (start) begin
      busy_q <= 1'b1;
      mode_q <= wdata[CTRL_START_BIT];
    end else if (arith_bus.done) begin
      busy_q <= 1'b0;
    end
  end

  // Indicators change only on completion; writes never reach them
  always_ff @(posedge clk) begin
    if (reset) begin
      zf_q <= FLAG_RST;
      vf_q <= FLAG_RST;
      nf_q <= FLAG_RST;
    end else if (arith_bus.done) begin
      if (mode_q == MODE_DIV) begin
        vf_q <= arith_bus.ovf;
        zf_q <= (new_lo == 8'h00);
        nf_q <= new_lo[7];
      end else begin
        vf_q <= 1'b0;
        zf_q <= ({new_hi, new_lo} == 16'h0000);
        nf_q <= new_hi[7];
      end
    end
  end

  // Read multiplexer; other units' gate bits and unmapped addresses read zero
  always_comb begin
    unique case (addr)
      ADDR_CLK_GATE: rd_mux = {gate_q, 3'b000};
      ADDR_SRC_LO: rd_mux = sr_q[3:0];
      ADDR_SRC_HI: rd_mux = sr_q[7:4];
      ADDR_DL_LO: rd_mux = dl_q[3:0];
      ADDR_DL_HI: rd_mux = dl_q[7:4];
      ADDR_DH_LO: rd_mux = dh_q[3:0];
      ADDR_DH_HI: rd_mux = dh_q[7:4];
      ADDR_CTRL: rd_mux = {nf_q, vf_q, zf_q, busy_q};
      default: rd_mux = 4'h0;
    endcase
  end

  // Registered read data, captured on the read strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= RDATA_RST;
    end else if (rd) begin
      rdata_q <= rd_mux;
    end
  end

  // Operand copy for the checks; kept apart from the sequencer so a capture bug shows
  always_ff @(posedge clk) begin
    if (start) begin
      chk_src_q <= sr_q;
      chk_dvd_q <= {dh_q, dl_q};
    end
  end

  // Gate write reads back one cycle later
  property p_gate_readback;
    @(posedge clk) disable iff (reset)
      (wr && addr == ADDR_CLK_GATE) |=> (gate_q == $past(wdata[GATE_BIT]));
  endproperty
  a_gate_readback: assert property (p_gate_readback) else $error("gate bit not stored");

  // Start sets busy and records the mode
  property p_start_busy;
    @(posedge clk) disable iff (reset)
      start |=> (busy_q && mode_q == $past(wdata[CTRL_START_BIT]));
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not reflected in busy");

  // Multiply clears overflow and zero follows the full product
  property p_mul_flags;
    @(posedge clk) disable iff (reset)
      (arith_bus.done && mode_q == MODE_MUL && !start)
        |=> (!vf_q && zf_q == ({dh_q, dl_q} == 16'h0000) && nf_q == dh_q[7]);
  endproperty
  a_mul_flags: assert property (p_mul_flags) else $error("multiply flags wrong");

  // Non-overflowing divide flags follow the quotient byte
  property p_div_flags;
    @(posedge clk) disable iff (reset)
      (arith_bus.done && mode_q == MODE_DIV && !arith_bus.ovf)
        |=> (!vf_q && zf_q == (dl_q == 8'h00) && nf_q == dl_q[7]);
  endproperty
  a_div_flags: assert property (p_div_flags) else $error("divide flags wrong");

  // Overflow keeps the dividend and raises the indicator
  property p_div_ovf_hold;
    @(posedge clk) disable iff (reset)
      (arith_bus.done && arith_bus.ovf && !wr)
        |=> (vf_q && dl_q == $past(dl_q) && dh_q == $past(dh_q));
  endproperty
  a_div_ovf_hold: assert property (p_div_ovf_hold) else $error("overflow changed destination");

  // Indicators never move without a completion
  property p_flags_stable;
    @(posedge clk) disable iff (reset)
      !arith_bus.done |=> $stable({nf_q, vf_q, zf_q});
  endproperty
  a_flags_stable: assert property (p_flags_stable) else $error("indicator changed by write");

  // Gated-off clock keeps the operation pending
  property p_gate_hold;
    @(posedge clk) disable iff (reset)
      (busy_q && !cpu_en) |=> busy_q;
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("operation ended without clock");

  // Source operand unchanged unless its nibbles are written
  property p_src_hold;
    @(posedge clk) disable iff (reset)
      !(wr && (addr == ADDR_SRC_LO || addr == ADDR_SRC_HI)) |=> $stable(sr_q);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("source operand changed");

  // Busy drops on completion unless a new start arrives
  property p_busy_clear;
    @(posedge clk) disable iff (reset)
      (arith_bus.done && !start) |=> !busy_q;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy stuck after completion");

  // Control read returns indicators and busy bit of the sampling cycle
  property p_rd_ctrl;
    @(posedge clk) disable iff (reset)
      (rd && addr == ADDR_CTRL)
        |=> (rdata_q == {$past(nf_q), $past(vf_q), $past(zf_q), $past(busy_q)});
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

  // Read data holds between read strobes
  property p_rdata_hold;
    @(posedge clk) disable iff (reset)
      !rd |=> $stable(rdata_q);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

  // Multiply loads the full product of the operands seen at start
  property p_mul_load;
    @(posedge clk) disable iff (reset)
      (arith_bus.done && mode_q == MODE_MUL)
        |=> ({dh_q, dl_q} == $past({8'h00, chk_dvd_q[7:0]} * {8'h00, chk_src_q}));
  endproperty
  a_mul_load: assert property (p_mul_load) else $error("product not loaded");

  // Non-overflowing divide loads quotient and remainder
  property p_div_load;
    @(posedge clk) disable iff (reset)
      (arith_bus.done && mode_q == MODE_DIV && !arith_bus.ovf)
        |=> (dl_q == $past(8'(chk_dvd_q / {8'h00, chk_src_q}))
          && dh_q == $past(8'(chk_dvd_q % {8'h00, chk_src_q})));
  endproperty
  a_div_load: assert property (p_div_load) else $error("quotient not loaded");

  // Overflow exactly when the divisor is zero or the quotient needs more than eight bits
  property p_ovf_rule;
    @(posedge clk) disable iff (reset)
      (arith_bus.done && mode_q == MODE_DIV)
        |-> (arith_bus.ovf == (chk_src_q == 8'h00
          || (chk_dvd_q / {8'h00, chk_src_q}) > 16'h00FF));
  endproperty
  a_ovf_rule: assert property (p_ovf_rule) else $error("overflow decision wrong");

  // Gate off stops the CPU enable from the next cycle
  property p_gate_no_en;
    @(posedge clk) disable iff (reset)
      !gate_q |=> !cpu_en;
  endproperty
  a_gate_no_en: assert property (p_gate_no_en) else $error("enable while gated off");

endmodule

//--- mul_div_unit_tb.sv
// Self-checking bench for the multiply/divide unit with an integer model
`timescale 1ns/1ps
module mul_div_unit_tb;
  import mdu_pkg::*;
  // Design ports
  logic clk; // 40 MHz clock
  logic reset; // Synchronous reset
  logic [15:0] addr; // I/O address
  logic wr; // Write strobe
  logic rd; // Read strobe
  logic [3:0] wdata; // Write nibble
  logic [3:0] rdata_q; // Read nibble
  // Bench state
  int fails = 0; // Mismatches
  int checks_done = 0; // Comparisons made
  int cyc = 0; // Cycles run, for the hang guard
  int m_src = 0; // Model copy of the source operand
  logic [7:0] got; // Last value read

  mdu_top #(.CPU_CLK_DIV(1)) u_mdu_top (.clk(clk), .reset(reset), .addr(addr), .wr(wr),
    .rd(rd), .wdata(wdata), .rdata_q(rdata_q));

  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard: about 40 ops of under 70 cycles each
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails = fails + 1;
      give_verdict();
    end
  end

  // Compare one read value with the model
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One nibble write; idle edge after so strobes never toggle twice at once
  task automatic wr_nib(input logic [15:0] a, input logic [3:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // One nibble read; data is registered at the sampling edge
  task automatic rd_nib(input logic [15:0] a);
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    got = {4'h0, rdata_q};
    @(posedge clk);
    #1;
  endtask

  // Byte access as two nibbles, low nibble at the lower address
  task automatic wr_byte(input logic [15:0] a, input logic [7:0] b);
    wr_nib(a, b[3:0]);
    wr_nib(a + 16'h0001, b[7:4]);
  endtask

  task automatic rd_byte(input logic [15:0] a);
    logic [3:0] lo;
    rd_nib(a);
    lo = got[3:0];
    rd_nib(a + 16'h0001);
    got = {got[3:0], lo};
  endtask

  task automatic wait_edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One operation; stall > 0 runs it with the clock gate off for a while
  task automatic run_op(input bit div, input int s, input int dl, input int dh,
    input bit wsrc, input int stall);
    int d;
    int el;
    int eh;
    bit vf;
    if (wsrc) begin
      wr_byte(ADDR_SRC_LO, 8'(s));
      m_src = s;
    end
    wr_byte(ADDR_DL_LO, 8'(dl));
    wr_byte(ADDR_DH_LO, 8'(dh));
    if (stall > 0) begin
      wr_nib(ADDR_CLK_GATE, 4'h0);
    end
    // Upper bits carry junk: indicator bits must ignore it
    wr_nib(ADDR_CTRL, {3'($urandom), div});
    rd_nib(ADDR_CTRL);
    chk({7'h00, got[0]}, 8'h01);
    if (stall > 0) begin
      wait_edges(stall);
      rd_nib(ADDR_CTRL);
      chk({7'h00, got[0]}, 8'h01);
      wr_nib(ADDR_CLK_GATE, 4'h8);
      wait_edges(14);
    end else begin
      wait_edges(7);
    end
    // Integer model of the unsigned arithmetic
    vf = 1'b0;
    if (!div) begin
      d = m_src * dl;
      el = d % 256;
      eh = d / 256;
    end else if (m_src == 0 || dh >= m_src) begin
      vf = 1'b1;
      el = dl;
      eh = dh;
    end else begin
      d = dh * 256 + dl;
      el = d / m_src;
      eh = d % m_src;
    end
    rd_nib(ADDR_CTRL);
    if (!div) begin
      chk(got, {4'h0, eh[7], 1'b0, d == 0, 1'b0});
    end else begin
      chk(got, {4'h0, el[7], vf, el == 0, 1'b0});
    end
    rd_byte(ADDR_DL_LO);
    chk(got, 8'(el));
    rd_byte(ADDR_DH_LO);
    chk(got, 8'(eh));
  endtask

  // Closing report
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    // Worked examples: mode, source, high byte, low byte
    logic [31:0] tbl [11] = '{32'h00640000, 32'h00580064, 32'h005800C8, 32'h00A500C8,
      32'h01641A16, 32'h0164332C, 32'h01580000, 32'h01132468, 32'h01130024,
      32'h01131168, 32'h01000100};
    addr = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 4'h0;
    reset = 1'b1;
    void'($urandom(53966));
    repeat (16) @(posedge clk);
    #1 reset = 1'b0;
    // Reset values, unmapped place, gate read back
    rd_nib(ADDR_CTRL);
    chk(got, 8'h00);
    rd_nib(ADDR_CLK_GATE);
    chk(got, 8'h00);
    rd_nib(16'hFF77);
    chk(got, 8'h00);
    wr_nib(ADDR_CLK_GATE, 4'h8);
    rd_nib(ADDR_CLK_GATE);
    chk(got, 8'h08);
    $display("test reset and gate finished");
    // Documented examples; multiply gets a junk high byte
    foreach (tbl[i]) begin
      run_op(tbl[i][24], tbl[i][23:16], tbl[i][7:0],
        tbl[i][24] ? int'(tbl[i][15:8]) : int'($urandom % 256), 1'b1, 0);
    end
    $display("test examples finished");
    // Random operations, source often kept from the previous one
    for (int i = 0; i < 24; i++) begin
      run_op($urandom % 2, $urandom % 256, $urandom % 256, $urandom % 256,
        ($urandom % 2) == 0, 0);
    end
    $display("test random finished");
    // Clock gate off holds a started division and a started multiplication pending
    run_op(1'b1, m_src, 8'h55, 8'h00, 1'b0, 20);
    run_op(1'b0, m_src, 8'hFF, 8'h00, 1'b0, 20);
    $display("test gated clock finished");
    give_verdict();
  end
endmodule
